// >>> inc/gjd_pkg.sv
// Behaviour
// RL1: pin_function_select picks first pin role: input, status, pll clock, fixed levels.
// RL2: general_output_invert flips only the driven level; detection uses raw pin level.
// RL3: routed pll clock is divided by pll_out_clock_divider plus one.
// RL4: after reset the first pin is an input, never driven.
// RL5: as input, first pin is chip select or detection per mode pin.
// RL6: three-wire mode forces first pin to chip select, whatever the function code.
// RL7: second and third pins are detection inputs only, never outputs.
// RL8: detection input is debounced on a slow tick of 2^21 master cycles.
// RL9: without slow_tick_enable no debounce and no output switching happens.
// RL10: debounced low selects enables_when_low, high selects enables_when_high.
// RL11: selected detection enable is ANDed with each output's normal enable.
// RL12: selected midrail_enable_override is ORed with the normal midrail enable.
// RL13: with detect_enable clear the jack enables read all ones.
// RL14: detect_pin_select 00 first, 01 second, 10 third pin; 11 reserved.
// RL15: software writes 1111 to both sets for outputs unaffected by jack.
// RL16: detection switching on the first pin works in two-wire mode.
// RL17: switch register bits 3:0 low set, 7:4 high set, output one lowest.
// RL18: debounced level changes after two equal samples on consecutive ticks.
// RL19: reserved detect_pin_select code makes the detection input constant zero.
package gjd_pkg;
    localparam logic [6:0] ADDR_PIN_CTRL = 7'h08;
    localparam logic [6:0] ADDR_DETECT_CFG = 7'h09;
    localparam logic [6:0] ADDR_OUT_SWITCH = 7'h0d;
    localparam logic [6:0] ADDR_STATUS = 7'h3f;
    localparam logic [8:0] RST_PIN_CTRL = 9'h000;
    localparam logic [8:0] RST_DETECT_CFG = 9'h000;
    localparam logic [8:0] RST_OUT_SWITCH = 9'h000;
    localparam int FUNC_LSB = 0;
    localparam int INV_BIT = 3;
    localparam int DIV_LSB = 4;
    localparam int SEL_LSB = 4;
    localparam int DETEN_BIT = 6;
    localparam int MID_LSB = 7;
    localparam int LOW_LSB = 0;
    localparam int HIGH_LSB = 4;
    localparam int NUM_OUTPUTS = 4;
    localparam int TICK_CYCLES_DEF = 2097152;
    typedef enum logic [2:0] {
        GJD_FN_INPUT = 3'b000,
        GJD_FN_RSVD = 3'b001,
        GJD_FN_TEMP_OK = 3'b010,
        GJD_FN_AUTO_MUTE = 3'b011,
        GJD_FN_PLL_CLK = 3'b100,
        GJD_FN_PLL_LOCK = 3'b101,
        GJD_FN_LOGIC0 = 3'b110,
        GJD_FN_LOGIC1 = 3'b111
    } gjd_func_t;
    typedef enum logic [1:0] {
        GJD_SEL_FIRST = 2'b00,
        GJD_SEL_SECOND = 2'b01,
        GJD_SEL_THIRD = 2'b10,
        GJD_SEL_RSVD = 2'b11
    } gjd_sel_t;
endpackage : gjd_pkg

// >>> logic/gjd_debounce.sv
`timescale 1ns/1ps
module gjd_debounce (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic sample_in,
    output logic level
);
    logic sample_r;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sample_r <= 1'b0;
        end else if (tick) begin
            sample_r <= sample_in;
        end
    end

    // a single odd sample between ticks never reaches the level
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            level <= 1'b0;
        end else if (tick && (sample_in == sample_r)) begin // RL18 RL8
            level <= sample_in;
        end
    end

    a_stable_two: assert property ( // RL18
        @(posedge clk_sys) disable iff (sys_rst)
        (level != $past(level)) |-> ($past(tick) && $past(sample_in) == level
            && $past(sample_r) == level)
    ) else $error("debounced level changed without two equal samples");

    a_hold_no_tick: assert property ( // RL9
        @(posedge clk_sys) disable iff (sys_rst)
        !tick |=> $stable(level)
    ) else $error("debounced level moved without a tick");
endmodule : gjd_debounce

// >>> logic/gjd_top.sv
`timescale 1ns/1ps
module gjd_top #(
    parameter int TICK_CYCLES = gjd_pkg::TICK_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic [6:0] reg_addr,
    input wire logic [8:0] reg_wr_data,
    output logic [8:0] reg_rd_data,
    input wire logic mode_three_wire,
    input wire logic first_multi_pin_in,
    output logic first_multi_pin_out,
    output logic first_multi_pin_oe,
    input wire logic second_multi_pin_in,
    input wire logic third_multi_pin_in,
    output logic chip_select_input,
    input wire logic temp_ok,
    input wire logic auto_mute_active,
    input wire logic pll_clk,
    input wire logic pll_lock,
    input wire logic slow_tick_enable,
    input wire logic [3:0] normal_out_en,
    input wire logic normal_midrail_en,
    output logic [3:0] out_en,
    output logic midrail_en,
    output logic detect_level
);
    localparam int CNT_W = $clog2(TICK_CYCLES);
    localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES - 1);

    logic [8:0] pin_ctrl_r;
    logic [8:0] detect_cfg_r;
    logic [8:0] out_switch_r;
    gjd_pkg::gjd_func_t func;
    gjd_pkg::gjd_sel_t sel;
    logic invert;
    logic [1:0] div_code;
    logic det_en;
    logic [1:0] mid_ovr;
    logic [3:0] en_low;
    logic [3:0] en_high;
    logic [3:0] jack_en;
    logic drive;
    logic gp_level;
    logic raw_detect;
    logic pll_q_r;
    logic pll_edge;
    logic [1:0] pll_cnt_r;
    logic pll_div_r;
    logic [CNT_W-1:0] tick_cnt_r;
    logic tick_r;
    logic [8:0] rd_nxt;

    // register file, written through the control interface word strobe
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pin_ctrl_r <= gjd_pkg::RST_PIN_CTRL; // RL4
        end else if (reg_wr_en && reg_addr == gjd_pkg::ADDR_PIN_CTRL) begin
            pin_ctrl_r <= reg_wr_data;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            detect_cfg_r <= gjd_pkg::RST_DETECT_CFG;
        end else if (reg_wr_en && reg_addr == gjd_pkg::ADDR_DETECT_CFG) begin
            detect_cfg_r <= reg_wr_data;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            out_switch_r <= gjd_pkg::RST_OUT_SWITCH;
        end else if (reg_wr_en && reg_addr == gjd_pkg::ADDR_OUT_SWITCH) begin
            out_switch_r <= reg_wr_data;
        end
    end

    always_comb begin
        unique case (reg_addr)
            gjd_pkg::ADDR_PIN_CTRL: rd_nxt = pin_ctrl_r;
            gjd_pkg::ADDR_DETECT_CFG: rd_nxt = detect_cfg_r;
            gjd_pkg::ADDR_OUT_SWITCH: rd_nxt = out_switch_r;
            gjd_pkg::ADDR_STATUS: rd_nxt = {6'h00, tick_r, first_multi_pin_oe, detect_level};
            default: rd_nxt = 9'h000;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rd_data <= 9'h000;
        end else begin
            reg_rd_data <= rd_nxt;
        end
    end

    // field views
    assign func = gjd_pkg::gjd_func_t'(pin_ctrl_r[gjd_pkg::FUNC_LSB +: 3]);
    assign invert = pin_ctrl_r[gjd_pkg::INV_BIT];
    assign div_code = pin_ctrl_r[gjd_pkg::DIV_LSB +: 2];
    assign sel = gjd_pkg::gjd_sel_t'(detect_cfg_r[gjd_pkg::SEL_LSB +: 2]);
    assign det_en = detect_cfg_r[gjd_pkg::DETEN_BIT];
    assign mid_ovr = detect_cfg_r[gjd_pkg::MID_LSB +: 2];
    assign en_low = out_switch_r[gjd_pkg::LOW_LSB +: 4]; // RL17
    assign en_high = out_switch_r[gjd_pkg::HIGH_LSB +: 4]; // RL17

    // pll clock divider: toggling every n input transitions keeps 50% duty for odd n too
    assign pll_edge = pll_clk ^ pll_q_r;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pll_q_r <= 1'b0;
        end else begin
            pll_q_r <= pll_clk;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pll_cnt_r <= 2'h0;
            pll_div_r <= 1'b0;
        end else if (pll_edge) begin
            if (pll_cnt_r == div_code) begin // RL3
                pll_cnt_r <= 2'h0;
                pll_div_r <= ~pll_div_r;
            end else begin
                pll_cnt_r <= pll_cnt_r + 2'h1;
            end
        end
    end

    // first pin output mux
    always_comb begin
        unique case (func) // RL1
            gjd_pkg::GJD_FN_INPUT: gp_level = 1'b0;
            gjd_pkg::GJD_FN_RSVD: gp_level = 1'b0;
            gjd_pkg::GJD_FN_TEMP_OK: gp_level = temp_ok;
            gjd_pkg::GJD_FN_AUTO_MUTE: gp_level = auto_mute_active;
            gjd_pkg::GJD_FN_PLL_CLK: gp_level = pll_div_r; // RL3
            gjd_pkg::GJD_FN_PLL_LOCK: gp_level = pll_lock;
            gjd_pkg::GJD_FN_LOGIC0: gp_level = 1'b0;
            gjd_pkg::GJD_FN_LOGIC1: gp_level = 1'b1;
        endcase
    end

    // reserved code stays undriven; three-wire mode owns the pin as chip select
    assign drive = !mode_three_wire && func != gjd_pkg::GJD_FN_INPUT
        && func != gjd_pkg::GJD_FN_RSVD; // RL6 RL1 RL4

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            first_multi_pin_out <= 1'b0;
            first_multi_pin_oe <= 1'b0; // RL4
        end else begin
            first_multi_pin_out <= drive & (gp_level ^ invert); // RL2
            first_multi_pin_oe <= drive;
        end
    end

    // idle chip select reads high when the pin is not an input
    assign chip_select_input = (mode_three_wire || func == gjd_pkg::GJD_FN_INPUT)
        ? first_multi_pin_in : 1'b1; // RL5 RL6

    // slow tick, held off entirely while disabled so nothing debounces
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (!slow_tick_enable) begin // RL9
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (tick_cnt_r == TICK_LAST) begin // RL8
            tick_cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + CNT_W'(1);
            tick_r <= 1'b0;
        end
    end

    // raw pin level, never the inverted output level
    always_comb begin
        unique case (sel) // RL14
            gjd_pkg::GJD_SEL_FIRST: raw_detect = !mode_three_wire & first_multi_pin_in; // RL2 RL16
            gjd_pkg::GJD_SEL_SECOND: raw_detect = second_multi_pin_in; // RL7
            gjd_pkg::GJD_SEL_THIRD: raw_detect = third_multi_pin_in; // RL7
            gjd_pkg::GJD_SEL_RSVD: raw_detect = 1'b0; // RL19
        endcase
    end

    gjd_debounce i_gjd_debounce (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick(tick_r),
        .sample_in(raw_detect),
        .level(detect_level)
    );

    // per-output gating; a frozen level keeps its enables while the tick is off
    for (genvar i = 0; i < gjd_pkg::NUM_OUTPUTS; i++) begin : g_out
        assign jack_en[i] = det_en ? (detect_level ? en_high[i] : en_low[i]) : 1'b1; // RL10 RL13

        always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
                out_en[i] <= 1'b0;
            end else begin
                out_en[i] <= normal_out_en[i] & jack_en[i]; // RL11
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            midrail_en <= 1'b0;
        end else begin
            midrail_en <= normal_midrail_en
                | (det_en & (detect_level ? mid_ovr[1] : mid_ovr[0])); // RL12
        end
    end

    a_reset_input: assert property ( // RL4
        @(posedge clk_sys) disable iff (sys_rst)
        (func == gjd_pkg::GJD_FN_INPUT) |=> !first_multi_pin_oe
    ) else $error("first pin driven while set as input");

    a_three_wire_cs: assert property ( // RL6
        @(posedge clk_sys) disable iff (sys_rst)
        mode_three_wire |-> (chip_select_input == first_multi_pin_in) ##1 !first_multi_pin_oe
    ) else $error("three-wire mode did not keep first pin as chip select");

    a_fixed_level: assert property ( // RL1
        @(posedge clk_sys) disable iff (sys_rst)
        (!mode_three_wire && func == gjd_pkg::GJD_FN_LOGIC1)
        |=> first_multi_pin_oe && (first_multi_pin_out == !$past(invert))
    ) else $error("fixed high function drove wrong level");

    a_invert_low: assert property ( // RL2
        @(posedge clk_sys) disable iff (sys_rst)
        (drive && func == gjd_pkg::GJD_FN_LOGIC0 && invert) |=> first_multi_pin_out
    ) else $error("inverted logic 0 not driven high");

    a_div_toggle: assert property ( // RL3
        @(posedge clk_sys) disable iff (sys_rst)
        (pll_edge && pll_cnt_r != div_code) |=> $stable(pll_div_r)
    ) else $error("pll divider toggled before its count");

    a_div_period: assert property ( // RL3
        @(posedge clk_sys) disable iff (sys_rst)
        (pll_edge && pll_cnt_r == div_code) |=> (pll_div_r != $past(pll_div_r))
    ) else $error("pll divider missed its toggle");

    a_tick_gate: assert property ( // RL9
        @(posedge clk_sys) disable iff (sys_rst)
        !slow_tick_enable |=> !tick_r && tick_cnt_r == '0
    ) else $error("slow tick ran while disabled");

    a_tick_period: assert property ( // RL8
        @(posedge clk_sys) disable iff (sys_rst)
        tick_r |-> ($past(tick_cnt_r) == TICK_LAST) ##1 !tick_r
    ) else $error("slow tick not at end of its period");

    a_detect_off: assert property ( // RL13
        @(posedge clk_sys) disable iff (sys_rst)
        !det_en |=> (out_en == $past(normal_out_en))
    ) else $error("outputs altered with detection disabled");

    a_and_gate: assert property ( // RL11
        @(posedge clk_sys) disable iff (sys_rst)
        (normal_out_en == 4'h0) |=> (out_en == 4'h0)
    ) else $error("output enabled without its normal enable");

    a_select_high: assert property ( // RL10
        @(posedge clk_sys) disable iff (sys_rst)
        (det_en && detect_level) |=> (out_en == ($past(normal_out_en) & $past(en_high)))
    ) else $error("high detection level used wrong enable set");

    a_midrail_or: assert property ( // RL12
        @(posedge clk_sys) disable iff (sys_rst)
        (normal_midrail_en || (det_en && !detect_level && mid_ovr[0])) |=> midrail_en
    ) else $error("midrail driver not forced on");

    // ticks are a period apart, so the check is on every cycle the reserved code is held
    a_reserved_sel: assert property ( // RL19
        @(posedge clk_sys) disable iff (sys_rst)
        (sel == gjd_pkg::GJD_SEL_RSVD) |=> !$rose(detect_level)
    ) else $error("reserved select raised the detection level");

    a_select_low: assert property ( // RL10
        @(posedge clk_sys) disable iff (sys_rst)
        (det_en && !detect_level) |=> (out_en == ($past(normal_out_en) & $past(en_low)))
    ) else $error("low detection level used wrong enable set");

    a_cs_follow: assert property ( // RL5
        @(posedge clk_sys) disable iff (sys_rst)
        (func == gjd_pkg::GJD_FN_INPUT) |-> (chip_select_input == first_multi_pin_in)
    ) else $error("input pin did not reach chip select");
endmodule : gjd_top

// >>> testbench/gjd_jack_model.sv
`timescale 1ns/1ps
module gjd_jack_model (
    input wire logic clk_sys,
    input wire logic plugged,
    input wire logic glitch,
    output logic jack_pin
);
    logic settled_r = 1'b0;
    int bounce_r = 0;
    // contacts chatter for five cycles on each change, shorter than one slow tick
    always @(posedge clk_sys) begin
        if (plugged != settled_r) begin
            settled_r <= plugged;
            bounce_r <= 5;
        end else if (bounce_r > 0) begin
            bounce_r <= bounce_r - 1;
        end
        if (bounce_r > 0)
            jack_pin <= ~jack_pin;
        else
            jack_pin <= settled_r ^ glitch;
    end
endmodule : gjd_jack_model

// >>> testbench/tb_gjd_top.sv
`timescale 1ns/1ps
module tb_gjd_top;
    localparam int TICK = 8;
    typedef struct {int k; logic [8:0] v;} gjd_note_t;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr_en = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [8:0] reg_wr_data = 9'h000;
    logic mode_three_wire = 1'b0;
    logic temp_ok = 1'b0, auto_mute_active = 1'b0, pll_clk = 1'b0, pll_lock = 1'b0;
    logic slow_tick_enable = 1'b0, normal_midrail_en = 1'b0, plugged = 1'b0;
    logic glitch = 1'b0, pll_run = 1'b0, lvl, drv, src;
    logic [3:0] normal_out_en = 4'h0;
    logic [2:0] pin_mask = 3'h0;
    logic [1:0] ovr, sel;
    logic [8:0] reg_rd_data, meas = 9'h000, got;
    logic first_multi_pin_out, first_multi_pin_oe, chip_select_input;
    logic midrail_en, detect_level, jack_pin;
    logic [3:0] out_en;
    wire logic p1 = jack_pin ^ pin_mask[0];
    wire logic p2 = jack_pin ^ pin_mask[1];
    wire logic p3 = jack_pin ^ pin_mask[2];
    int failures = 0, comparisons = 0, seed = 32'h46aab8b2, c, s, p;
    gjd_note_t q[$];
    gjd_note_t n;
    string nm[6] = '{"rd_data", "pin", "out_en", "detect_level", "chip_select", "pll_period"};

    gjd_top #(.TICK_CYCLES(TICK)) i_gjd_top (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .mode_three_wire(mode_three_wire),
        .first_multi_pin_in(p1), .first_multi_pin_out(first_multi_pin_out),
        .first_multi_pin_oe(first_multi_pin_oe), .second_multi_pin_in(p2),
        .third_multi_pin_in(p3), .chip_select_input(chip_select_input), .temp_ok(temp_ok),
        .auto_mute_active(auto_mute_active), .pll_clk(pll_clk), .pll_lock(pll_lock),
        .slow_tick_enable(slow_tick_enable), .normal_out_en(normal_out_en),
        .normal_midrail_en(normal_midrail_en), .out_en(out_en), .midrail_en(midrail_en),
        .detect_level(detect_level));
    gjd_jack_model i_gjd_jack_model (.clk_sys(clk_sys), .plugged(plugged), .glitch(glitch),
        .jack_pin(jack_pin));

    always #10 clk_sys = ~clk_sys;
    // pll clock toggles every four system cycles, well below half the system rate
    always begin
        repeat (4) @(negedge clk_sys);
        if (pll_run)
            pll_clk = ~pll_clk;
    end

    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic expect_val(input int k, input logic [8:0] v);
        q.push_back('{k, v});
        // lets the checker sample before the driver moves any input
        #1;
    endtask : expect_val
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(negedge clk_sys);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [8:0] e);
        @(negedge clk_sys);
        reg_addr = a;
        @(negedge clk_sys);
        expect_val(0, e);
    endtask : rd
    task automatic wait_det(input logic e);
        int i;
        for (i = 0; i < 6 * TICK && detect_level !== e; i++) @(negedge clk_sys);
        if (detect_level !== e) begin
            failures++;
            print_verdict();
        end
        repeat (3 * TICK) @(negedge clk_sys);
    endtask : wait_det
    task automatic period();
        int i;
        logic o;
        repeat (40) @(negedge clk_sys);
        o = first_multi_pin_out;
        for (i = 0; i < 40 && first_multi_pin_out === o; i++) @(negedge clk_sys);
        o = first_multi_pin_out;
        for (i = 0; i < 40 && first_multi_pin_out === o; i++) @(negedge clk_sys);
        meas = i[8:0];
    endtask : period

    // results are judged apart from the driver, oldest note first
    initial forever begin
        wait (q.size() != 0);
        n = q.pop_front();
        case (n.k)
            0: got = reg_rd_data;
            1: got = {7'h00, first_multi_pin_oe, first_multi_pin_out};
            2: got = {4'h0, midrail_en, out_en};
            3: got = {8'h00, detect_level};
            4: got = {8'h00, chip_select_input};
            default: got = meas;
        endcase
        comparisons++;
        if (got !== n.v) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm[n.k], n.v, got);
        end
    end

    initial begin
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'b0;
        expect_val(1, 9'h000);
        rd(gjd_pkg::ADDR_PIN_CTRL, gjd_pkg::RST_PIN_CTRL);
        rd(gjd_pkg::ADDR_DETECT_CFG, gjd_pkg::RST_DETECT_CFG);
        rd(gjd_pkg::ADDR_OUT_SWITCH, gjd_pkg::RST_OUT_SWITCH);
        rd(7'h20, 9'h000);
        $display("test reset done");
        for (c = 0; c < 16; c++) begin
            if (c[2:0] == 3'b100)
                continue;
            temp_ok = $random(seed);
            auto_mute_active = $random(seed);
            pll_lock = $random(seed);
            pin_mask = $random(seed);
            wr(gjd_pkg::ADDR_PIN_CTRL, {5'h00, c[3:0]});
            case (c[2:0])
                3'b010: src = temp_ok;
                3'b011: src = auto_mute_active;
                3'b101: src = pll_lock;
                default: src = c[0];
            endcase
            drv = c[2:0] > 3'b001;
            expect_val(1, {7'h00, drv, drv & (src ^ c[3])});
            expect_val(4, {8'h00, (c[2:0] != 3'b000) | p1});
        end
        mode_three_wire = 1'b1;
        wr(gjd_pkg::ADDR_PIN_CTRL, 9'h007);
        expect_val(1, 9'h000);
        expect_val(4, {8'h00, p1});
        mode_three_wire = 1'b0;
        $display("test pin functions done");
        pll_run = 1'b1;
        for (c = 0; c < 4; c++) begin
            wr(gjd_pkg::ADDR_PIN_CTRL, {3'h0, c[1:0], 4'h4});
            period();
            expect_val(5, 9'(4 * (c + 1)));
        end
        pll_run = 1'b0;
        $display("test pll divider done");
        wr(gjd_pkg::ADDR_PIN_CTRL, 9'h008);
        wr(gjd_pkg::ADDR_OUT_SWITCH, 9'h0a5);
        rd(gjd_pkg::ADDR_OUT_SWITCH, 9'h0a5);
        slow_tick_enable = 1'b1;
        for (s = 0; s < 5; s++) begin
            sel = (s == 4) ? 2'b00 : s[1:0];
            pin_mask = (s > 2) ? 3'h0 : ~(3'h1 << s);
            mode_three_wire = (s == 4);
            ovr = $random(seed);
            normal_out_en = $random(seed);
            normal_midrail_en = $random(seed);
            wr(gjd_pkg::ADDR_DETECT_CFG, {ovr, 1'b1, sel, 4'h0});
            for (p = 0; p < 2; p++) begin
                plugged = p[0];
                lvl = (s > 2) ? 1'b0 : p[0];
                wait_det(lvl);
                expect_val(3, {8'h00, lvl});
                expect_val(2, {4'h0, ovr[lvl] | normal_midrail_en,
                    normal_out_en & (lvl ? 4'ha : 4'h5)});
            end
        end
        mode_three_wire = 1'b0;
        wait_det(1'b1);
        // a glitch one tick period long is caught by exactly one tick
        glitch = 1'b1;
        repeat (TICK) @(negedge clk_sys);
        glitch = 1'b0;
        wait_det(1'b1);
        expect_val(3, 9'h001);
        slow_tick_enable = 1'b0;
        plugged = 1'b0;
        repeat (6 * TICK) @(negedge clk_sys);
        expect_val(3, 9'h001);
        rd(gjd_pkg::ADDR_STATUS, 9'h001);
        slow_tick_enable = 1'b1;
        wait_det(1'b0);
        expect_val(3, 9'h000);
        wr(gjd_pkg::ADDR_OUT_SWITCH, 9'h000);
        wr(gjd_pkg::ADDR_DETECT_CFG, 9'h180);
        expect_val(2, {4'h0, normal_midrail_en, normal_out_en});
        $display("test detection done");
        repeat (2) @(negedge clk_sys);
        print_verdict();
    end
endmodule : tb_gjd_top
